// ==== inc/jtag_mux_pkg.sv ====
// Shared constants for the backplane port multiplexer
package jtag_mux_pkg;
   localparam int LOCAL_PORTS = 3;              // Local ports one to three carry full scan pins
   localparam int SEL_W = 4;                    // Port select: bit 0 is local port zero
   localparam int PT_W = 2;                     // Pass-through bits per port
   localparam int WORD_W = 8;                   // Captured scan word width
   localparam int SLOT_W = 8;                   // Interrogation response width
   localparam int BIT_CNT_W = 3;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
   localparam int BUF_DEPTH = 2;
   localparam int SYS_SYNC_W = 21;              // Pins and link flags entering the system clock
   localparam int LINK_SYNC_W = SLOT_W + 2;     // Levels entering the link clock
   localparam logic OE_OFF = 1'b1;              // Output enables are active low
   localparam logic OE_ON = 1'b0;
   localparam logic TRST_ASSERT = 1'b0;
   localparam logic TRST_IDLE = 1'b1;
   localparam logic SELECT_B0 = 1'b0;           // Master select value that picks port B0
   localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
   localparam logic [SLOT_W-1:0] SLOT_RESET = 8'h00;
   localparam logic [PT_W-1:0] PT_RESET = 2'h0;
   localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
   localparam logic [SEL_W-1:0] SEL_ONE = 4'h1;
endpackage

// ==== verilog/sync2.sv ====
// Two-flop level synchroniser, one bit per lane
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q <= '0;
      end else if (en) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ==== verilog/buf2.sv ====
// Two-entry valid/ready buffer
module buf2 #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic en,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [W-1:0] mem_reg [0:1];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Full and empty come straight from the occupancy count
   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = mem_reg[rd_ptr_reg];

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else if (en) begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ==== verilog/jtag_backplane_port_mux.sv ====
// Backplane port selection, local port fan-out and scan word capture
// Overview of operation
// - Port six reset level input affects only port six test reset output.
// - Scan data enters only through the current master port data input.
// - Master select picks master port; the other becomes bidirectional local port zero.
// - Master mode select steps own TAP and the local chain TAPs.
// - Master data output returns the lowest selected local chain data, else zero.
// - During interrogation the master data output presents the response.
// - Master test clock is the only scan clock, supplied by the master.
// - Master test reset low asynchronously initialises the link-domain scan capture and response registers.
// - Backplane mode, clock, reset pins drive when acting as local port; data out drives only when acting as master.
// - Five notify outputs go high while their data output is tri-stated.
// - Master pass-through inputs feed the single selected local port outputs.
// - Master pass-through outputs come from local port zero or one when selected alone, tri-stateable.
// - Pass-through is disabled when more than one local port is selected.
// - Master select 0 picks port B0, otherwise port B1.
// - Output enable high tri-states all local scan port outputs.
module jtag_backplane_port_mux (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic test_clock,
   input wire logic test_reset_n,
   input wire logic master_port_select,
   input wire logic local_output_enable_n,
   input wire logic local_reset_level_input,
   input wire logic port6_reset_level_input,
   input wire logic tap_in_reset,
   input wire logic tdo_active,
   input wire logic interrogation_active,
   input wire logic [jtag_mux_pkg::SLOT_W-1:0] slot_response,
   input wire logic [jtag_mux_pkg::SEL_W-1:0] port_select,
   input wire logic tdi_b0_in,
   input wire logic tdi_b1_in,
   input wire logic tms_b0_in,
   output logic tms_b0_out,
   output logic tms_b0_oe_n,
   input wire logic tms_b1_in,
   output logic tms_b1_out,
   output logic tms_b1_oe_n,
   input wire logic tck_b0_in,
   output logic tck_b0_out,
   output logic tck_b0_oe_n,
   input wire logic tck_b1_in,
   output logic tck_b1_out,
   output logic tck_b1_oe_n,
   input wire logic trst_b0_n_in,
   output logic trst_b0_n_out,
   output logic trst_b0_oe_n,
   input wire logic trst_b1_n_in,
   output logic trst_b1_n_out,
   output logic trst_b1_oe_n,
   input wire logic tdo_b0_in,
   output logic tdo_b0_out,
   output logic tdo_b0_oe_n,
   input wire logic tdo_b1_in,
   output logic tdo_b1_out,
   output logic tdo_b1_oe_n,
   output logic tristate_notify_out_b0,
   output logic tristate_notify_out_b1,
   output logic [jtag_mux_pkg::LOCAL_PORTS-1:0] tristate_notify_out_local,
   input wire logic [jtag_mux_pkg::PT_W-1:0] pass_through_in_b0,
   input wire logic [jtag_mux_pkg::PT_W-1:0] pass_through_in_b1,
   output logic [jtag_mux_pkg::PT_W-1:0] pass_through_out_b0,
   output logic pass_through_b0_oe_n,
   output logic [jtag_mux_pkg::PT_W-1:0] pass_through_out_b1,
   output logic pass_through_b1_oe_n,
   input wire logic [jtag_mux_pkg::PT_W-1:0] pass_through_in_p1,
   output logic [jtag_mux_pkg::PT_W-1:0] pass_through_out_p1,
   output logic pass_through_p1_oe_n,
   input wire logic [jtag_mux_pkg::LOCAL_PORTS-1:0] local_tdi_in,
   output logic [jtag_mux_pkg::LOCAL_PORTS-1:0] local_tdo_out,
   output logic [jtag_mux_pkg::LOCAL_PORTS-1:0] local_tdo_oe_n,
   output logic [jtag_mux_pkg::LOCAL_PORTS-1:0] local_tms_out,
   output logic [jtag_mux_pkg::LOCAL_PORTS-1:0] local_tck_out,
   output logic [jtag_mux_pkg::LOCAL_PORTS-1:0] local_trst_n_out,
   output logic local_scan_oe_n,
   output logic port6_trst_n_out,
   output logic port6_trst_oe_n,
   output logic [jtag_mux_pkg::WORD_W-1:0] scan_word,
   output logic scan_word_valid,
   input wire logic scan_word_ready,
   output logic scan_overrun
);
   // Link domain: master test clock
   logic [jtag_mux_pkg::LINK_SYNC_W-1:0] link_sync;
   logic [jtag_mux_pkg::WORD_W-1:0] shift_reg;
   logic [jtag_mux_pkg::WORD_W-1:0] word_reg;
   logic [jtag_mux_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
   logic word_toggle_reg;
   logic [jtag_mux_pkg::SLOT_W-1:0] resp_shift_reg;
   logic resp_bit_reg;
   logic [jtag_mux_pkg::LINK_SYNC_W-1:0] link_async;

   assign link_async = {slot_response, interrogation_active, master_port_select};

   // Levels from outside the link clock pass two flops first
   sync2 #(.W(jtag_mux_pkg::LINK_SYNC_W)) link_sync_i (
      .clk(test_clock),
      .rst_n(test_reset_n),
      .en(1'b1),
      .d(link_async),
      .q(link_sync)
   );

   wire link_master_b1 = link_sync[0];
   wire link_interrogate = link_sync[1];
   wire [jtag_mux_pkg::SLOT_W-1:0] link_slot = link_sync[jtag_mux_pkg::LINK_SYNC_W-1:2];
   // Data pins belong to the test clock, so they are sampled directly
   wire master_tdi = link_master_b1 ? tdi_b1_in : tdi_b0_in;
   wire [jtag_mux_pkg::WORD_W-1:0] shift_next = {master_tdi, shift_reg[jtag_mux_pkg::WORD_W-1:1]};

   // Scan data capture, LSB first; reset acts without a clock edge
   always_ff @(posedge test_clock or negedge test_reset_n) begin
      if (!test_reset_n) begin
         shift_reg <= jtag_mux_pkg::WORD_RESET;
         word_reg <= jtag_mux_pkg::WORD_RESET;
         bit_cnt_reg <= '0;
         word_toggle_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == jtag_mux_pkg::LAST_BIT) begin
            word_reg <= shift_next; // Held for eight test clocks, long enough to cross
            word_toggle_reg <= ~word_toggle_reg;
         end
      end
   end

   // Interrogation response shifter: loads while idle, shifts while active
   always_ff @(posedge test_clock or negedge test_reset_n) begin
      if (!test_reset_n) begin
         resp_shift_reg <= jtag_mux_pkg::SLOT_RESET;
         resp_bit_reg <= 1'b0;
      end else begin
         if (!link_interrogate) begin
            resp_shift_reg <= link_slot;
         end else begin
            resp_shift_reg <= {1'b0, resp_shift_reg[jtag_mux_pkg::SLOT_W-1:1]};
         end
         resp_bit_reg <= resp_shift_reg[0];
      end
   end

   // System domain
   logic [jtag_mux_pkg::SYS_SYNC_W-1:0] sys_sync;
   logic [jtag_mux_pkg::SYS_SYNC_W-1:0] sys_async;

   assign sys_async = {word_toggle_reg, resp_bit_reg, local_output_enable_n, pass_through_in_p1,
                       local_tdi_in, pass_through_in_b1, tdo_b1_in, trst_b1_n_in, tck_b1_in, tms_b1_in,
                       pass_through_in_b0, tdo_b0_in, trst_b0_n_in, tck_b0_in, tms_b0_in, master_port_select};

   // Port pins, local data, enable, master select and link flags cross on two flops; port select, status and level inputs are used directly
   sync2 #(.W(jtag_mux_pkg::SYS_SYNC_W)) sys_sync_i (
      .clk(clock),
      .rst_n(rst_n),
      .en(clk_en),
      .d(sys_async),
      .q(sys_sync)
   );

   // Named views of the synchronised inputs
   wire master_b1 = (sys_sync[0] != jtag_mux_pkg::SELECT_B0);
   wire tms_b0_s = sys_sync[1];
   wire tck_b0_s = sys_sync[2];
   wire trst_b0_s = sys_sync[3];
   wire tdo_b0_s = sys_sync[4];
   wire [1:0] pt_b0_s = sys_sync[6:5];
   wire tms_b1_s = sys_sync[7];
   wire tck_b1_s = sys_sync[8];
   wire trst_b1_s = sys_sync[9];
   wire tdo_b1_s = sys_sync[10];
   wire [1:0] pt_b1_s = sys_sync[12:11];
   wire [2:0] ltdi_s = sys_sync[15:13];
   wire [1:0] pt_p1_s = sys_sync[17:16];
   wire oe_off_s = sys_sync[18];
   wire resp_bit_s = sys_sync[19];
   wire word_toggle_s = sys_sync[20];

   // Master and slave port views
   wire m_tms = master_b1 ? tms_b1_s : tms_b0_s;
   wire m_tck = master_b1 ? tck_b1_s : tck_b0_s;
   wire m_trst_n = master_b1 ? trst_b1_s : trst_b0_s;
   wire [1:0] m_pt = master_b1 ? pt_b1_s : pt_b0_s;
   wire s_tdo = master_b1 ? tdo_b0_s : tdo_b1_s; // Local port zero returns on its data output pin
   wire [1:0] s_pt = master_b1 ? pt_b0_s : pt_b1_s;

   // Local reset: forced by master reset, else level while TAPs sit in reset
   wire loc_trst_n = !m_trst_n ? jtag_mux_pkg::TRST_ASSERT :
                     tap_in_reset ? local_reset_level_input : jtag_mux_pkg::TRST_IDLE;
   wire p6_trst_n = !m_trst_n ? jtag_mux_pkg::TRST_ASSERT :
                    tap_in_reset ? port6_reset_level_input : jtag_mux_pkg::TRST_IDLE;

   // Returned data: lowest selected local port, else zero
   wire [3:0] ret_src = {ltdi_s, s_tdo};
   wire ret_sel = port_select[0] ? ret_src[0] : port_select[1] ? ret_src[1] :
                  port_select[2] ? ret_src[2] : port_select[3] ? ret_src[3] : 1'b0;
   wire master_tdo = interrogation_active ? resp_bit_s : ret_sel;
   wire master_tdo_oe_n = tdo_active ? jtag_mux_pkg::OE_ON : jtag_mux_pkg::OE_OFF;

   // Pass-through only for exactly one selected port
   wire pt_single = (port_select != jtag_mux_pkg::SEL_NONE) &&
                    ((port_select & (port_select - jtag_mux_pkg::SEL_ONE)) == jtag_mux_pkg::SEL_NONE);
   wire pt_p0 = pt_single && port_select[0];
   wire pt_p1 = pt_single && port_select[1];
   wire [1:0] m_pt_ret = pt_p0 ? s_pt : pt_p1 ? pt_p1_s : jtag_mux_pkg::PT_RESET;
   wire slave_drive_oe_n = oe_off_s ? jtag_mux_pkg::OE_OFF : jtag_mux_pkg::OE_ON;
   wire m_pt_oe_n = pt_single ? jtag_mux_pkg::OE_ON : jtag_mux_pkg::OE_OFF;
   wire s_pt_oe_n = (pt_p0 && !oe_off_s) ? jtag_mux_pkg::OE_ON : jtag_mux_pkg::OE_OFF;
   wire p1_pt_oe_n = (pt_p1 && !oe_off_s) ? jtag_mux_pkg::OE_ON : jtag_mux_pkg::OE_OFF;

   // Local ports one to three: enabled data out only when selected
   wire [2:0] ltdo_oe_n = (oe_off_s ? 3'h7 : ~port_select[3:1]);

   // Backplane port B0 pins, direction follows its role
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tms_b0_out <= 1'b0;
         tck_b0_out <= 1'b0;
         trst_b0_n_out <= jtag_mux_pkg::TRST_ASSERT;
         tdo_b0_out <= 1'b0;
         tms_b0_oe_n <= jtag_mux_pkg::OE_OFF;
         tdo_b0_oe_n <= jtag_mux_pkg::OE_OFF;
      end else if (clk_en) begin
         tms_b0_out <= m_tms;
         tck_b0_out <= m_tck;
         trst_b0_n_out <= loc_trst_n;
         tdo_b0_out <= master_tdo;
         tms_b0_oe_n <= master_b1 ? slave_drive_oe_n : jtag_mux_pkg::OE_OFF;
         tdo_b0_oe_n <= master_b1 ? jtag_mux_pkg::OE_OFF : master_tdo_oe_n;
      end
   end

   // Backplane port B1 pins, mirror of B0
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tms_b1_out <= 1'b0;
         tck_b1_out <= 1'b0;
         trst_b1_n_out <= jtag_mux_pkg::TRST_ASSERT;
         tdo_b1_out <= 1'b0;
         tms_b1_oe_n <= jtag_mux_pkg::OE_OFF;
         tdo_b1_oe_n <= jtag_mux_pkg::OE_OFF;
      end else if (clk_en) begin
         tms_b1_out <= m_tms;
         tck_b1_out <= m_tck;
         trst_b1_n_out <= loc_trst_n;
         tdo_b1_out <= master_tdo;
         tms_b1_oe_n <= master_b1 ? jtag_mux_pkg::OE_OFF : slave_drive_oe_n;
         tdo_b1_oe_n <= master_b1 ? master_tdo_oe_n : jtag_mux_pkg::OE_OFF;
      end
   end

   // Clock and reset enables follow mode select
   assign tck_b0_oe_n = tms_b0_oe_n;
   assign trst_b0_oe_n = tms_b0_oe_n;
   assign tck_b1_oe_n = tms_b1_oe_n;
   assign trst_b1_oe_n = tms_b1_oe_n;
   // Notify mirrors the registered data output enables
   assign tristate_notify_out_b0 = tdo_b0_oe_n;
   assign tristate_notify_out_b1 = tdo_b1_oe_n;
   assign tristate_notify_out_local = local_tdo_oe_n;
   assign port6_trst_oe_n = local_scan_oe_n;

   // Local ports one to three and port six reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         local_tms_out <= '0;
         local_tck_out <= '0;
         local_trst_n_out <= '0;
         local_tdo_out <= '0;
         local_tdo_oe_n <= '1;
         local_scan_oe_n <= jtag_mux_pkg::OE_OFF;
         port6_trst_n_out <= jtag_mux_pkg::TRST_ASSERT;
      end else if (clk_en) begin
         local_tms_out <= {3{m_tms}};
         local_tck_out <= {3{m_tck}};
         local_trst_n_out <= {3{loc_trst_n}};
         local_tdo_out <= 3'h0;
         local_tdo_oe_n <= ltdo_oe_n;
         local_scan_oe_n <= slave_drive_oe_n;
         port6_trst_n_out <= p6_trst_n;
      end
   end

   // Pass-through outputs
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pass_through_out_b0 <= jtag_mux_pkg::PT_RESET;
         pass_through_out_b1 <= jtag_mux_pkg::PT_RESET;
         pass_through_out_p1 <= jtag_mux_pkg::PT_RESET;
         pass_through_b0_oe_n <= jtag_mux_pkg::OE_OFF;
         pass_through_b1_oe_n <= jtag_mux_pkg::OE_OFF;
         pass_through_p1_oe_n <= jtag_mux_pkg::OE_OFF;
      end else if (clk_en) begin
         pass_through_out_b0 <= master_b1 ? m_pt : m_pt_ret;
         pass_through_out_b1 <= master_b1 ? m_pt_ret : m_pt;
         pass_through_out_p1 <= m_pt;
         pass_through_b0_oe_n <= master_b1 ? s_pt_oe_n : m_pt_oe_n;
         pass_through_b1_oe_n <= master_b1 ? m_pt_oe_n : s_pt_oe_n;
         pass_through_p1_oe_n <= p1_pt_oe_n;
      end
   end

   // Word arrival: toggle edge marks a new stable word from the link side
   logic word_toggle_d_reg;
   logic buf_in_ready;
   wire word_event = word_toggle_s ^ word_toggle_d_reg;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         word_toggle_d_reg <= 1'b0;
         scan_overrun <= 1'b0;
      end else if (clk_en) begin
         word_toggle_d_reg <= word_toggle_s;
         // Test clock cannot stall, so a word with no room is lost
         if (word_event && !buf_in_ready) begin
            scan_overrun <= 1'b1;
         end
      end
   end

   // Two entries absorb a receiver stall of up to two words
   buf2 #(.W(jtag_mux_pkg::WORD_W)) word_buf_i (
      .clock(clock),
      .rst_n(rst_n),
      .en(clk_en),
      .in_data(word_reg),
      .in_valid(word_event),
      .in_ready(buf_in_ready),
      .out_data(scan_word),
      .out_valid(scan_word_valid),
      .out_ready(scan_word_ready)
   );
endmodule

// ==== dv/jtag_port_mux_monitor.sv ====
// Checker for the backplane port multiplexer outputs
module jtag_port_mux_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic test_reset_n,
   input wire logic local_output_enable_n,
   input wire logic local_reset_level_input,
   input wire logic port6_reset_level_input,
   input wire logic tap_in_reset,
   input wire logic [jtag_mux_pkg::SEL_W-1:0] port_select,
   input wire logic tms_b0_oe_n,
   input wire logic tms_b1_oe_n,
   input wire logic tdo_b0_oe_n,
   input wire logic tdo_b1_oe_n,
   input wire logic tristate_notify_out_b0,
   input wire logic tristate_notify_out_b1,
   input wire logic pass_through_p1_oe_n,
   input wire logic [jtag_mux_pkg::LOCAL_PORTS-1:0] local_trst_n_out,
   input wire logic local_scan_oe_n,
   input wire logic port6_trst_n_out,
   input wire logic [jtag_mux_pkg::WORD_W-1:0] scan_word,
   input wire logic scan_word_valid,
   input wire logic scan_word_ready,
   input wire logic scan_overrun
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Pins take three edges to reach the outputs
   sequence s_oe_off;
      local_output_enable_n [*4];
   endsequence
   sequence s_multi;
      ($countones(port_select) > 1) [*2];
   endsequence
   sequence s_trst_low;
      !test_reset_n [*4];
   endsequence
   sequence s_port6_up;
      (tap_in_reset && test_reset_n && port6_reset_level_input && !local_reset_level_input) [*4];
   endsequence
   AST_ONE_DRIVER: assert property (tms_b0_oe_n || tms_b1_oe_n)
      else $error("both backplane ports drive");
   AST_NOTIFY_B0: assert property (tristate_notify_out_b0 == tdo_b0_oe_n)
      else $error("b0 notify differs from tdo enable");
   AST_NOTIFY_B1: assert property (tristate_notify_out_b1 == tdo_b1_oe_n)
      else $error("b1 notify differs from tdo enable");
   AST_OE_OFF: assert property (s_oe_off |-> local_scan_oe_n && tms_b0_oe_n && tms_b1_oe_n)
      else $error("local drive not released");
   AST_PT_OFF: assert property (s_multi |-> pass_through_p1_oe_n)
      else $error("pass-through driven with several ports");
   AST_TRST_LOW: assert property (s_trst_low |-> local_trst_n_out == 3'h0)
      else $error("local reset not forced low");
   AST_PORT6: assert property (s_port6_up |-> port6_trst_n_out && local_trst_n_out == 3'h0)
      else $error("port six level leaks");
   AST_HOLD: assert property (scan_word_valid && !scan_word_ready && clk_en |=> scan_word_valid && $stable(scan_word))
      else $error("stalled word changed");
   AST_OVERRUN: assert property (scan_overrun |=> scan_overrun)
      else $error("overrun flag dropped");
endmodule

// ==== dv/jtag_master_model.sv ====
// Behavioural scan master on the backplane
module jtag_master_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 40; // 80 ns link clock
   // Idle mode and data pins sit at pull-up; clock stops low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b0;
      #100;
      trst_n = 1'b1;
   end
   task automatic drive_tms(input logic v);
      #1 tms = v;
   endtask
   // Clock is still, so release avoids its edges
   task automatic reset_pulse();
      trst_n = 1'b0;
      #400;
      trst_n = 1'b1;
   endtask
   // Data changes while the clock is low
   task automatic send_byte(input logic [7:0] b);
      #7;
      for (int i = 0; i < 8; i++) begin
         tdi = b[i];
         #HALF tck = 1'b1;
         #HALF tck = 1'b0;
      end
      tdi = 1'b1;
   endtask
endmodule

// ==== dv/jtag_backplane_port_mux_tb.sv ====
// Self-checking bench for the backplane port multiplexer
module jtag_backplane_port_mux_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, rst_n, clk_en, test_clock, test_reset_n, master_port_select, local_output_enable_n;
   logic local_reset_level_input, port6_reset_level_input, tap_in_reset, tdo_active, interrogation_active;
   logic [jtag_mux_pkg::SLOT_W-1:0] slot_response;
   logic [jtag_mux_pkg::SEL_W-1:0] port_select;
   logic tdi_b0_in, tdi_b1_in, tms_b0_in, tms_b0_out, tms_b0_oe_n, tms_b1_in, tms_b1_out, tms_b1_oe_n;
   logic tck_b0_in, tck_b0_out, tck_b0_oe_n, tck_b1_in, tck_b1_out, tck_b1_oe_n;
   logic trst_b0_n_in, trst_b0_n_out, trst_b0_oe_n, trst_b1_n_in, trst_b1_n_out, trst_b1_oe_n;
   logic tdo_b0_in, tdo_b0_out, tdo_b0_oe_n, tdo_b1_in, tdo_b1_out, tdo_b1_oe_n;
   logic tristate_notify_out_b0, tristate_notify_out_b1, pass_through_b0_oe_n, pass_through_b1_oe_n;
   logic pass_through_p1_oe_n, local_scan_oe_n, port6_trst_n_out, port6_trst_oe_n;
   logic scan_word_valid, scan_word_ready, scan_overrun, m_tck, m_tms, m_tdi, m_trst_n, lp0;
   logic [jtag_mux_pkg::LOCAL_PORTS-1:0] tristate_notify_out_local, local_tdi_in, local_tdo_out, local_tdo_oe_n;
   logic [jtag_mux_pkg::LOCAL_PORTS-1:0] local_tms_out, local_tck_out, local_trst_n_out;
   logic [jtag_mux_pkg::PT_W-1:0] pass_through_in_b0, pass_through_in_b1, pass_through_out_b0;
   logic [jtag_mux_pkg::PT_W-1:0] pass_through_out_b1, pass_through_in_p1, pass_through_out_p1;
   logic [jtag_mux_pkg::WORD_W-1:0] scan_word;
   int miscompares, compares, cycles;
   // Pads: released slave mode and reset pins float high; released clock and data out pins read inverted
   assign test_clock = m_tck;
   assign test_reset_n = m_trst_n;
   assign tdi_b0_in = master_port_select ? 1'b1 : m_tdi;
   assign tdi_b1_in = master_port_select ? m_tdi : 1'b1;
   assign tms_b0_in = master_port_select ? (tms_b0_oe_n ? 1'b1 : tms_b0_out) : m_tms;
   assign tms_b1_in = master_port_select ? m_tms : (tms_b1_oe_n ? 1'b1 : tms_b1_out);
   assign tck_b0_in = master_port_select ? (tck_b0_oe_n ? ~tck_b0_out : tck_b0_out) : m_tck;
   assign tck_b1_in = master_port_select ? m_tck : (tck_b1_oe_n ? ~tck_b1_out : tck_b1_out);
   assign trst_b0_n_in = master_port_select ? (trst_b0_oe_n ? 1'b1 : trst_b0_n_out) : m_trst_n;
   assign trst_b1_n_in = master_port_select ? m_trst_n : (trst_b1_oe_n ? 1'b1 : trst_b1_n_out);
   assign tdo_b0_in = master_port_select ? lp0 : (tdo_b0_oe_n ? ~tdo_b0_out : tdo_b0_out);
   assign tdo_b1_in = master_port_select ? (tdo_b1_oe_n ? ~tdo_b1_out : tdo_b1_out) : lp0;
   jtag_backplane_port_mux u_jtag_backplane_port_mux (.*);
   jtag_master_model u_jtag_master_model (.tck(m_tck), .tms(m_tms), .tdi(m_tdi), .trst_n(m_trst_n));
   // 40 MHz clock and hang limit
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares = miscompares + 1;
         report_and_stop();
      end
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Both master choices; slave and local tms follow
   task automatic t_route();
      for (int s = 0; s < 2; s++) begin
         master_port_select <= s[0];
         u_jtag_master_model.drive_tms(1'b0);
         wait_clk(5);
         chk("slave tms", 8'h00, {7'h00, s[0] ? tms_b0_out : tms_b1_out});
         chk("slave oe", 8'h00, {7'h00, s[0] ? tms_b0_oe_n : tms_b1_oe_n});
         chk("master oe", 8'h01, {7'h00, s[0] ? tms_b1_oe_n : tms_b0_oe_n});
         chk("local tms", 8'h00, {5'h00, local_tms_out});
         u_jtag_master_model.drive_tms(1'b1);
         wait_clk(5);
         chk("slave tms", 8'h01, {7'h00, s[0] ? tms_b0_out : tms_b1_out});
         chk("local tms", 8'h07, {5'h00, local_tms_out});
      end
      $display("test route done");
   endtask
   task automatic t_oe();
      local_output_enable_n <= 1'b1;
      wait_clk(5);
      chk("local oe", 8'h01, {7'h00, local_scan_oe_n});
      chk("slave oe", 8'h01, {7'h00, tms_b0_oe_n});
      local_output_enable_n <= 1'b0;
      wait_clk(5);
      chk("local oe", 8'h00, {7'h00, local_scan_oe_n});
      $display("test oe done");
   endtask
   // One port, then two ports
   task automatic t_pass();
      port_select <= 4'h2;
      pass_through_in_b1 <= 2'h2;
      pass_through_in_p1 <= 2'h1;
      wait_clk(5);
      chk("port1 y", 8'h02, {6'h00, pass_through_out_p1});
      chk("master y", 8'h01, {6'h00, pass_through_out_b1});
      chk("master y oe", 8'h00, {7'h00, pass_through_b1_oe_n});
      port_select <= 4'h3;
      wait_clk(5);
      chk("port1 y oe", 8'h01, {7'h00, pass_through_p1_oe_n});
      chk("master y oe", 8'h01, {7'h00, pass_through_b1_oe_n});
      $display("test pass done");
   endtask
   task automatic t_tdo();
      port_select <= 4'h2;
      local_tdi_in <= 3'h1;
      tdo_active <= 1'b1;
      wait_clk(6);
      chk("tdo oe", 8'h00, {7'h00, tdo_b1_oe_n});
      chk("notify", 8'h00, {7'h00, tristate_notify_out_b1});
      chk("tdo", 8'h01, {7'h00, tdo_b1_out});
      local_tdi_in <= 3'h0;
      wait_clk(6);
      chk("tdo", 8'h00, {7'h00, tdo_b1_out});
      tdo_active <= 1'b0;
      wait_clk(6);
      chk("notify", 8'h01, {7'h00, tristate_notify_out_b1});
      $display("test tdo done");
   endtask
   task automatic t_trst();
      tap_in_reset <= 1'b1;
      port6_reset_level_input <= 1'b1;
      wait_clk(5);
      chk("port6 trst", 8'h01, {7'h00, port6_trst_n_out});
      chk("local trst", 8'h00, {5'h00, local_trst_n_out});
      local_reset_level_input <= 1'b1;
      port6_reset_level_input <= 1'b0;
      wait_clk(5);
      chk("port6 trst", 8'h00, {7'h00, port6_trst_n_out});
      chk("local trst", 8'h07, {5'h00, local_trst_n_out});
      fork
         u_jtag_master_model.reset_pulse();
         begin
            wait_clk(8);
            chk("local trst", 8'h00, {5'h00, local_trst_n_out});
         end
      join
      tap_in_reset <= 1'b0;
      $display("test trst done");
   endtask
   // Three words, reader stalled: third lost; first is all ones while the link select settles
   task automatic t_scan();
      u_jtag_master_model.send_byte(8'hff);
      u_jtag_master_model.send_byte(8'ha5);
      u_jtag_master_model.send_byte(8'h81);
      wait_clk(10);
      chk("overrun", 8'h01, {7'h00, scan_overrun});
      for (int i = 0; i < 2; i++) begin
         chk("valid", 8'h01, {7'h00, scan_word_valid});
         chk("word", i ? 8'ha5 : 8'hff, scan_word);
         scan_word_ready <= 1'b1;
         @(posedge clock);
         scan_word_ready <= 1'b0;
         wait_clk(3);
      end
      chk("valid", 8'h00, {7'h00, scan_word_valid});
      $display("test scan done");
   endtask
   initial begin
      cycles = 0;
      miscompares = 0;
      compares = 0;
      rst_n = 1'b0;
      clk_en = 1'b1;
      master_port_select = 1'b0;
      local_output_enable_n = 1'b0;
      local_reset_level_input = 1'b0;
      port6_reset_level_input = 1'b0;
      tap_in_reset = 1'b0;
      tdo_active = 1'b0;
      interrogation_active = 1'b0;
      slot_response = 8'h00;
      port_select = 4'h0;
      pass_through_in_b0 = 2'h3;
      pass_through_in_b1 = 2'h0;
      pass_through_in_p1 = 2'h0;
      local_tdi_in = 3'h0;
      scan_word_ready = 1'b0;
      lp0 = 1'b0;
      wait_clk(6);
      rst_n <= 1'b1;
      wait_clk(3);
      t_route();
      t_oe();
      t_pass();
      t_tdo();
      t_trst();
      t_scan();
      report_and_stop();
   end
endmodule
bind jtag_backplane_port_mux jtag_port_mux_monitor u_jtag_port_mux_monitor (.*);
